// [common/wdt_pkg.sv]
// Constants, register layout and phase type of the watchdog
package wdt_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WDT_CNT_W = 18;
  localparam int WDT_SEL_W = 3;
  localparam int WDT_DATA_W = 32;
  localparam int WDT_ADDR_W = 12;
  localparam int WDT_ADDR_LSB = 2;

  // ----------------------------------------------------------------
  // Timing in watchdog clocks
  // ----------------------------------------------------------------
  localparam int unsigned WDT_DELAY_TICKS = 1024;
  localparam int unsigned WDT_HOLD_TICKS = 64;
  localparam int WDT_SEL_SCALE = 2;
  localparam int WDT_SEL_BASE = 4;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [WDT_ADDR_W-1:0] WDT_CTRL_OFS = 12'h000;
  localparam logic [WDT_DATA_W-1:0] WDT_CTRL_RESET = 32'h0000_0700;
  localparam int WDT_B_STROBE = 0;
  localparam int WDT_B_RESET_FUNCTION_ENABLE = 1;
  localparam int WDT_B_RESET_OCCURRED_FLAG = 2;
  localparam int WDT_B_FLAG = 3;
  localparam int WDT_B_IRQEN = 6;
  localparam int WDT_B_RUN = 7;
  localparam int WDT_B_SEL = 8;

  // ----------------------------------------------------------------
  // Bus encoding
  // ----------------------------------------------------------------
  localparam int WDT_HTRANS_ACT = 1;

  // ----------------------------------------------------------------
  // Phases of the counter
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WDT_S_COUNT,
    WDT_S_DELAY,
    WDT_S_HOLD
  } wdt_phase_t;

endpackage

// [common/wdt_tick_if.sv]
// Watchdog clock tick carrier between tick source and core
interface wdt_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface

// [hdl/wdt_tick.sv]
// Watchdog clock pin synchroniser and rising edge tick source
module wdt_tick
  import wdt_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic wdog_clk_in,
  wdt_tick_if.src tk
);

  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic tick;
  } wdt_tick_st_t;

  localparam wdt_tick_st_t TICK_RST = '{default: 1'b0};

  wdt_tick_st_t s_r;
  wdt_tick_st_t s_nxt;

  // ----------------------------------------------------------------
  // Filter and edge detect
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sync = {s_r.sync[1:0], wdog_clk_in};
    s_nxt.tick = 1'b0;
    if (s_r.sync[2] == s_r.sync[1] && s_r.sync[1] != s_r.lvl)
    begin
      s_nxt.lvl = s_r.sync[1];
      s_nxt.tick = s_r.sync[1];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= TICK_RST;
    else if (ce)
      s_r <= s_nxt;
  end

  assign tk.tick = s_r.tick;

  property p_tick_level;
    @(posedge hclk) disable iff (!hresetn)
    s_r.tick && $past(ce) |-> s_r.lvl && !$past(s_r.lvl);
  endproperty
  a_tick_level: assert property (p_tick_level)
    else $error("tick without rising filtered level");

endmodule

// [hdl/wdt_top.sv]
// Watchdog timer core with AHB-Lite control register
// Summary of operation
// - 18-bit up-counter advanced by watchdog clock
// - Run bit starts counting; clearing resets counter
// - Reaching interval sets flag, requests interrupt
// - Flag set even with interrupt disabled
// - Flag cleared only by writing one
// - Interval is two to (2*select+4) clocks
// - Reset follows 1024 clocks after time-out
// - Clear strobe self-clears on the same clock as counter reset
// - Expired delay sets reset flag, resets CPU
// - CPU reset lasts 64 watchdog clocks
// - Reset flag survives the watchdog reset
// - Writes need unlock; flags always clearable
// - Reset enable gates CPU reset and flag
// - Reset flag at bit two, write one
// - Clear strobe at bit zero, zero ignored
module wdt_top
  import wdt_pkg::*;
#(
  parameter int unsigned DELAY_TICKS = WDT_DELAY_TICKS,
  parameter int unsigned HOLD_TICKS = WDT_HOLD_TICKS
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [WDT_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [WDT_DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [WDT_DATA_W-1:0] hrdata,
  input wire logic sys_unlocked,
  input wire logic wdog_clk_in,
  output logic timeout_irq,
  output logic cpu_reset_req
);

  localparam int DW = $clog2(DELAY_TICKS);
  localparam int HW = $clog2(HOLD_TICKS);
  localparam logic [DW-1:0] DLY_LAST = DW'(DELAY_TICKS - 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_TICKS - 1);

  typedef struct packed {
    wdt_phase_t phase;
    logic [WDT_CNT_W-1:0] cnt;
    logic [DW-1:0] dly;
    logic [HW-1:0] hold;
    logic [WDT_SEL_W-1:0] interval_select;
    logic watchdog_run_enable;
    logic timeout_irq_enable;
    logic reset_function_enable;
    logic counter_clear_strobe;
    logic timeout_flag;
    logic reset_occurred_flag;
    logic wr_pend;
    logic [WDT_DATA_W-1:0] hrdata;
  } wdt_regs_t;

  localparam wdt_regs_t S_RST = '{
    phase: WDT_S_COUNT,
    cnt: '0,
    dly: '0,
    hold: '0,
    interval_select: WDT_CTRL_RESET[WDT_B_SEL +: WDT_SEL_W],
    watchdog_run_enable: WDT_CTRL_RESET[WDT_B_RUN],
    timeout_irq_enable: WDT_CTRL_RESET[WDT_B_IRQEN],
    reset_function_enable: WDT_CTRL_RESET[WDT_B_RESET_FUNCTION_ENABLE],
    counter_clear_strobe: WDT_CTRL_RESET[WDT_B_STROBE],
    timeout_flag: WDT_CTRL_RESET[WDT_B_FLAG],
    reset_occurred_flag: WDT_CTRL_RESET[WDT_B_RESET_OCCURRED_FLAG],
    wr_pend: 1'b0,
    hrdata: '0
  };

  wdt_regs_t s_r;
  wdt_regs_t s_nxt;
  wdt_tick_if tk_if ();
  logic tick;
  logic addr_hit;
  logic set_to;
  logic set_rst;
  logic clr_to;
  logic clr_rst;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [WDT_CNT_W-1:0] last_count(
    input logic [WDT_SEL_W-1:0] sel
  );
    logic [WDT_CNT_W:0] full;
    logic [WDT_CNT_W:0] m;
    full = (WDT_CNT_W + 1)'(1) << (WDT_SEL_SCALE * int'(sel) + WDT_SEL_BASE);
    m = full - (WDT_CNT_W + 1)'(1);
    return m[WDT_CNT_W-1:0];
  endfunction

  function automatic logic [WDT_DATA_W-1:0] pack_word(input wdt_regs_t r);
    logic [WDT_DATA_W-1:0] w;
    w = '0;
    w[WDT_B_SEL +: WDT_SEL_W] = r.interval_select;
    w[WDT_B_RUN] = r.watchdog_run_enable;
    w[WDT_B_IRQEN] = r.timeout_irq_enable;
    w[WDT_B_FLAG] = r.timeout_flag;
    w[WDT_B_RESET_OCCURRED_FLAG] = r.reset_occurred_flag;
    w[WDT_B_RESET_FUNCTION_ENABLE] = r.reset_function_enable;
    w[WDT_B_STROBE] = r.counter_clear_strobe;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Watchdog clock tick source
  // ----------------------------------------------------------------
  wdt_tick u_tick (
    .hclk (hclk),
    .hresetn (hresetn),
    .ce (ce),
    .wdog_clk_in (wdog_clk_in),
    .tk (tk_if.src)
  );

  assign tick = tk_if.tick;
  assign addr_hit =
    haddr[WDT_ADDR_W-1:WDT_ADDR_LSB] == WDT_CTRL_OFS[WDT_ADDR_W-1:WDT_ADDR_LSB];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    set_to = 1'b0;
    set_rst = 1'b0;
    clr_to = 1'b0;
    clr_rst = 1'b0;
    if (s_r.counter_clear_strobe)
      s_nxt.counter_clear_strobe = 1'b0;
    if (s_r.phase == WDT_S_HOLD)
    begin
      if (tick)
      begin
        if (s_r.hold == HOLD_LAST)
        begin
          s_nxt.phase = WDT_S_COUNT;
          s_nxt.cnt = '0;
        end
        else
          s_nxt.hold = s_r.hold + 1'b1;
      end
    end
    else if (s_r.counter_clear_strobe || !s_r.watchdog_run_enable)
    begin
      s_nxt.cnt = '0;
      s_nxt.dly = '0;
      s_nxt.phase = WDT_S_COUNT;
    end
    else if (tick)
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
      case (s_r.phase)
        WDT_S_COUNT:
        begin
          if (s_r.cnt == last_count(s_r.interval_select))
          begin
            set_to = 1'b1;
            s_nxt.phase = WDT_S_DELAY;
            s_nxt.dly = '0;
          end
        end
        WDT_S_DELAY:
        begin
          if (s_r.dly == DLY_LAST)
          begin
            if (s_r.reset_function_enable)
            begin
              set_rst = 1'b1;
              s_nxt.phase = WDT_S_HOLD;
              s_nxt.hold = '0;
            end
            else
            begin
              s_nxt.phase = WDT_S_COUNT;
              s_nxt.cnt = '0;
            end
          end
          else
            s_nxt.dly = s_r.dly + 1'b1;
        end
        default:
        begin
          s_nxt.phase = WDT_S_COUNT;
        end
      endcase
    end
    if (s_r.wr_pend)
    begin
      if (sys_unlocked)
      begin
        s_nxt.interval_select = hwdata[WDT_B_SEL +: WDT_SEL_W];
        s_nxt.watchdog_run_enable = hwdata[WDT_B_RUN];
        s_nxt.timeout_irq_enable = hwdata[WDT_B_IRQEN];
        s_nxt.reset_function_enable = hwdata[WDT_B_RESET_FUNCTION_ENABLE];
        if (hwdata[WDT_B_STROBE])
          s_nxt.counter_clear_strobe = 1'b1;
      end
      clr_to = hwdata[WDT_B_FLAG];
      clr_rst = hwdata[WDT_B_RESET_OCCURRED_FLAG];
    end
    s_nxt.timeout_flag = set_to || (s_r.timeout_flag && !clr_to);
    s_nxt.reset_occurred_flag =
      set_rst || (s_r.reset_occurred_flag && !clr_rst);
    s_nxt.wr_pend = hsel && hready && htrans[WDT_HTRANS_ACT] && hwrite &&
      addr_hit;
    if (hsel && hready && htrans[WDT_HTRANS_ACT] && !hwrite && addr_hit)
      s_nxt.hrdata = pack_word(s_nxt);
    else
      s_nxt.hrdata = '0;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= S_RST;
    else if (ce)
      s_r <= s_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = s_r.hrdata;
  assign timeout_irq = s_r.timeout_flag && s_r.timeout_irq_enable;
  assign cpu_reset_req = s_r.phase == WDT_S_HOLD;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_timeout_sets_flag;
    @(posedge hclk) disable iff (!hresetn)
    (ce && tick && s_r.phase == WDT_S_COUNT && s_r.watchdog_run_enable &&
     !s_r.counter_clear_strobe &&
     s_r.cnt == last_count(s_r.interval_select))
    |=> s_r.timeout_flag && s_r.phase == WDT_S_DELAY;
  endproperty
  a_timeout_sets_flag: assert property (p_timeout_sets_flag)
    else $error("time-out did not set flag");

  property p_flag_without_irq;
    @(posedge hclk) disable iff (!hresetn)
    (ce && tick && s_r.phase == WDT_S_COUNT && s_r.watchdog_run_enable &&
     !s_r.counter_clear_strobe && !s_r.timeout_irq_enable &&
     !(s_r.wr_pend && sys_unlocked) &&
     s_r.cnt == last_count(s_r.interval_select))
    |=> s_r.timeout_flag && !timeout_irq;
  endproperty
  a_flag_without_irq: assert property (p_flag_without_irq)
    else $error("flag wrong with interrupt disabled");

  property p_disable_clears;
    @(posedge hclk) disable iff (!hresetn)
    (ce && !s_r.watchdog_run_enable && s_r.phase != WDT_S_HOLD)
    |=> s_r.cnt == '0;
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("disabled watchdog kept its count");

  property p_flag_sticky;
    @(posedge hclk) disable iff (!hresetn)
    (s_r.timeout_flag && !(ce && s_r.wr_pend && hwdata[WDT_B_FLAG]))
    |=> s_r.timeout_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("time-out flag lost without write of one");

  property p_strobe_auto;
    @(posedge hclk) disable iff (!hresetn)
    (ce && s_r.counter_clear_strobe && s_r.phase != WDT_S_HOLD &&
     !s_r.wr_pend)
    |=> !s_r.counter_clear_strobe && s_r.cnt == '0;
  endproperty
  a_strobe_auto: assert property (p_strobe_auto)
    else $error("clear strobe did not reset counter and self-clear");

  property p_delay_resets;
    @(posedge hclk) disable iff (!hresetn)
    (ce && tick && s_r.phase == WDT_S_DELAY && s_r.dly == DLY_LAST &&
     s_r.watchdog_run_enable && !s_r.counter_clear_strobe &&
     s_r.reset_function_enable)
    |=> cpu_reset_req && s_r.reset_occurred_flag;
  endproperty
  a_delay_resets: assert property (p_delay_resets)
    else $error("expired delay did not reset CPU");

  property p_no_reset_disabled;
    @(posedge hclk) disable iff (!hresetn)
    (ce && s_r.phase != WDT_S_HOLD && !s_r.reset_function_enable &&
     !s_r.wr_pend)
    |=> !cpu_reset_req && s_r.reset_occurred_flag ==
        $past(s_r.reset_occurred_flag);
  endproperty
  a_no_reset_disabled: assert property (p_no_reset_disabled)
    else $error("reset generated while reset function disabled");

  property p_hold_length;
    @(posedge hclk) disable iff (!hresetn)
    (cpu_reset_req && !(ce && tick && s_r.hold == HOLD_LAST))
    |=> cpu_reset_req;
  endproperty
  a_hold_length: assert property (p_hold_length)
    else $error("CPU reset released early");

  property p_hold_start;
    @(posedge hclk) disable iff (!hresetn)
    $rose(cpu_reset_req) |-> s_r.hold == '0;
  endproperty
  a_hold_start: assert property (p_hold_start)
    else $error("CPU reset hold count not started at zero");

  property p_locked_write;
    @(posedge hclk) disable iff (!hresetn)
    (ce && s_r.wr_pend && !sys_unlocked)
    |=> s_r.watchdog_run_enable == $past(s_r.watchdog_run_enable) &&
        s_r.interval_select == $past(s_r.interval_select) &&
        s_r.reset_function_enable == $past(s_r.reset_function_enable);
  endproperty
  a_locked_write: assert property (p_locked_write)
    else $error("locked write changed protected bits");

  property p_reset_occurred_flag_sticky;
    @(posedge hclk) disable iff (!hresetn)
    (s_r.reset_occurred_flag && !(ce && s_r.wr_pend && hwdata[WDT_B_RESET_OCCURRED_FLAG]))
    |=> s_r.reset_occurred_flag;
  endproperty
  a_reset_occurred_flag_sticky: assert property (p_reset_occurred_flag_sticky)
    else $error("reset flag lost without write of one");

  property p_irq_drops;
    @(posedge hclk) disable iff (!hresetn)
    (ce && s_r.wr_pend && hwdata[WDT_B_FLAG] && !set_to) |=> !timeout_irq;
  endproperty
  a_irq_drops: assert property (p_irq_drops)
    else $error("interrupt stayed high after flag cleared");

  c_timeout: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(s_r.timeout_flag));
  c_cpu_reset: cover property (@(posedge hclk) disable iff (!hresetn)
    $fell(cpu_reset_req));
  c_strobe: cover property (@(posedge hclk) disable iff (!hresetn)
    s_r.counter_clear_strobe && s_r.phase == WDT_S_DELAY);
  c_locked: cover property (@(posedge hclk) disable iff (!hresetn)
    ce && s_r.wr_pend && !sys_unlocked);

endmodule

// [dv/wdt_cpu_model.sv]
// Processor side model: watches watchdog interrupt and reset request
module wdt_cpu_model
  import wdt_pkg::*;
(
  input wire logic hclk,
  input wire logic wdog_clk_in,
  input wire logic timeout_irq,
  input wire logic cpu_reset_req,
  output int pulses,
  output int hold_ticks,
  output int delay_ticks
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pin_q = 1'b0;
  logic irq_q = 1'b0;
  logic rst_q = 1'b0;
  int dcnt = 0;
  int hcnt = 0;

  initial
  begin
    pulses = 0;
    hold_ticks = 0;
    delay_ticks = 0;
  end

  // ----------------------------------------------------------------
  // Tick counting between interrupt, reset entry and reset exit
  // ----------------------------------------------------------------
  always @(posedge hclk)
  begin
    pin_q <= wdog_clk_in;
    irq_q <= timeout_irq;
    rst_q <= cpu_reset_req;
    if (timeout_irq && !irq_q)
      dcnt <= 0;
    else if (wdog_clk_in && !pin_q)
      dcnt <= dcnt + 1;
    if (cpu_reset_req && !rst_q)
    begin
      delay_ticks <= dcnt;
      hcnt <= 0;
    end
    else if (cpu_reset_req && wdog_clk_in && !pin_q)
      hcnt <= hcnt + 1;
    // Core held in reset until request drops
    if (!cpu_reset_req && rst_q)
    begin
      pulses <= pulses + 1;
      hold_ticks <= hcnt;
    end
  end
endmodule

// [dv/tb_wdt_top.sv]
// Self-checking testbench of the watchdog block
module tb_wdt_top
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DLY = 8;
  localparam int HLD = 4;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic wdog_clk_in = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic sys_unlocked = 1'b0;
  logic ce_in = 1'b1;
  logic hreadyout, hresp, timeout_irq, cpu_reset_req;
  logic [31:0] hrdata;
  logic rd_dp = 1'b0;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int cmp_count = 0;
  int pulses, hold_ticks, delay_ticks, n, tmo;
  logic [2:0] sel;

  always #10 hclk = ~hclk;

  initial
  begin
    #7;
    forever #80 wdog_clk_in = ~wdog_clk_in;
  end

  wdt_top #(.DELAY_TICKS(DLY), .HOLD_TICKS(HLD)) dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce_in), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sys_unlocked(sys_unlocked), .wdog_clk_in(wdog_clk_in),
    .timeout_irq(timeout_irq), .cpu_reset_req(cpu_reset_req)
  );

  wdt_cpu_model cpu (
    .hclk(hclk), .wdog_clk_in(wdog_clk_in), .timeout_irq(timeout_irq),
    .cpu_reset_req(cpu_reset_req), .pulses(pulses),
    .hold_ticks(hold_ticks), .delay_ticks(delay_ticks)
  );

  // ----------------------------------------------------------------
  // Compare, bus and wait tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic [11:0] a, input logic w,
                     input logic [31:0] d, input logic unl);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    if (!w)
      exp_q.push_back(d);
    do @(posedge hclk); while (hready_s() !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0000_0000;
    sys_unlocked <= unl;
    do @(posedge hclk); while (hready_s() !== 1'b1);
  endtask

  function automatic logic hready_s();
    return hreadyout;
  endfunction

  task automatic wait_for(input int which, input int lim);
    n = 0;
    while (n < lim && ((which == 0) ? timeout_irq !== 1'b1 :
           (which == 1) ? cpu_reset_req !== 1'b1 : cpu_reset_req !== 1'b0))
    begin
      @(posedge hclk);
      n++;
    end
    if (n >= lim)
      chk("wait_limit", 32'h0, 32'h1);
  endtask

  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Read data monitor
  // ----------------------------------------------------------------
  always @(posedge hclk)
  begin
    if (rd_dp && hreadyout)
    begin
      chk("hrdata", exp_q.pop_front(), hrdata);
      chk("hresp", 32'h0, 32'(hresp));
    end
    if (hreadyout)
      rd_dp <= hsel && htrans[1] && !hwrite;
  end

  initial
  begin
    #200000;
    num_errors++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'hA86C));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(12'h000, 1'b0, 32'h0000_0700, 1'b0);
    bus(12'h004, 1'b0, 32'h0000_0000, 1'b0);
    bus(12'h000, 1'b1, 32'h0000_00C0, 1'b0);
    bus(12'h000, 1'b0, 32'h0000_0700, 1'b0);
    sel = 3'($urandom % 3);
    bus(12'h000, 1'b1, {21'h0, sel, 8'hC0}, 1'b1);
    bus(12'h000, 1'b0, {21'h0, sel, 8'hC0}, 1'b0);
    wait_for(0, 5000);
    tmo = (1 << (2 * sel + 4)) * 8;
    chk("irq_early", 32'h1, 32'(n >= tmo - 16));
    chk("irq_late", 32'h1, 32'(n <= tmo + 16));
    bus(12'h000, 1'b0, {21'h0, sel, 8'hC8}, 1'b0);
    bus(12'h000, 1'b1, {21'h0, sel, 8'hC0}, 1'b1);
    bus(12'h000, 1'b0, {21'h0, sel, 8'hC8}, 1'b0);
    bus(12'h000, 1'b1, 32'h0000_0008, 1'b0);
    bus(12'h000, 1'b0, {21'h0, sel, 8'hC0}, 1'b0);
    chk("irq_drop", 32'h0, 32'(timeout_irq));
    repeat ((DLY + 4) * 8) @(posedge hclk);
    chk("no_reset", 32'h0, 32'(pulses));
    bus(12'h000, 1'b1, 32'h0000_0089, 1'b1);
    repeat (3) @(posedge hclk);
    bus(12'h000, 1'b0, 32'h0000_0080, 1'b0);
    repeat (160) @(posedge hclk);
    bus(12'h000, 1'b0, 32'h0000_0088, 1'b0);
    chk("irq_masked", 32'h0, 32'(timeout_irq));
    bus(12'h000, 1'b1, 32'h0000_00CB, 1'b1);
    repeat (6)
    begin
      repeat (80) @(posedge hclk);
      bus(12'h000, 1'b1, 32'h0000_00C3, 1'b1);
      chk("kick_irq", 32'h0, 32'(timeout_irq));
    end
    chk("kick_rst", 32'h0, 32'(pulses));
    repeat (60) @(posedge hclk);
    ce_in <= 1'b0;
    repeat (200) @(posedge hclk);
    chk("hready_frozen", 32'h0, 32'(hreadyout));
    chk("irq_frozen", 32'h0, 32'(timeout_irq));
    ce_in <= 1'b1;
    wait_for(1, 400);
    wait_for(2, 400);
    @(posedge hclk);
    chk("pulses", 32'h1, 32'(pulses));
    chk("delay", 32'(DLY), 32'(delay_ticks));
    chk("hold", 32'(HLD), 32'(hold_ticks));
    bus(12'h000, 1'b0, 32'h0000_00CE, 1'b0);
    bus(12'h000, 1'b1, 32'h0000_0004, 1'b0);
    bus(12'h000, 1'b0, 32'h0000_00CA, 1'b0);
    bus(12'h000, 1'b1, 32'h0000_000A, 1'b1);
    bus(12'h000, 1'b0, 32'h0000_0002, 1'b0);
    repeat (320) @(posedge hclk);
    chk("stopped", 32'h1, 32'(pulses));
    chk("stop_irq", 32'h0, 32'(timeout_irq));
    chk("q_empty", 32'h0, 32'(exp_q.size()));
    final_report();
  end
endmodule
